// File: verilog/xip_write_pkg.sv
// Constants and types shared by the continuous-write front end
// Functional notes
// - Mode byte with upper nibble A puts a fast write into continuous mode.
// - Without continuous mode selected, every frame must start with the full opcode.
// - Dual-edge fast write enters continuous mode only on mode byte exactly A5.
// - Continuous dual-edge fast write takes the address right after select falls.
// - Any other dual-edge mode byte leaves that command's continuous mode.
// - Two-lane data write takes opcode, address and mode on lane 0 serially.
// - Two-lane data write data arrives two bits per clock, MSB on lane 1.
// - Continuous two-lane data write skips its opcode; other mode byte ends it.
// - Two-lane address/data write takes opcode serially, then address two bits per clock.
// - Two-lane address/data write data arrives two bits per clock, MSB on lane 1.
// - Continuous two-lane address/data write skips its opcode; other mode byte ends it.
// - Four-lane data write takes header serially, then uses all four lanes.
// - Four-lane data arrives four bits per clock, bit 7 on lane 3 first.
// - Continuous four-lane data write skips its opcode; other mode byte ends it.
// - Writes execute only while the write enable latch is one.
// - The write enable latch is never cleared by these writes.
// - Address increments per data byte, wrapping from 1FFFFF to zero.
// - Dual-edge writes move address and data on both clock edges.
// - Write enable latch is bit 1 of the first status register.
package xip_write_pkg;

    localparam logic [7:0]  OP_FAST        = 8'hDA;
    localparam logic [7:0]  OP_DDR_FAST    = 8'hDD;
    localparam logic [7:0]  OP_TWO_DATA    = 8'hA2;
    localparam logic [7:0]  OP_TWO_ADDR    = 8'hA1;
    localparam logic [7:0]  OP_FOUR_DATA   = 8'h32;

    localparam logic [3:0]  MODE_CONT_NIB  = 4'hA;
    localparam logic [7:0]  MODE_DDR_CONT  = 8'hA5;

    localparam int          ADDR_W         = 21;
    localparam logic [20:0] ADDR_MAX       = 21'h1FFFFF;
    localparam logic [20:0] ADDR_ZERO      = 21'h000000;
    localparam logic [1:0]  ADDR_LAST_BYTE = 2'h2;
    localparam logic [3:0]  BYTE_BITS      = 4'h8;
    localparam logic [3:0]  WIDTH_ONE      = 4'h1;
    localparam logic [3:0]  WIDTH_TWO      = 4'h2;
    localparam logic [3:0]  WIDTH_FOUR     = 4'h4;
    localparam int          LANES          = 4;
    localparam int          WEL_BIT        = 1;
    localparam int          SYNC_STAGES    = 3;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_FAST, CMD_DDR_FAST, CMD_TWO_DATA, CMD_TWO_ADDR, CMD_FOUR_DATA
    } cmd_t;

    typedef enum logic [2:0] {
        ST_START, ST_OPCODE, ST_ADDR, ST_MODE, ST_DATA, ST_IGNORE
    } link_state_t;

endpackage

// File: verilog/toggle_sync_if.sv
// Carrier between the write decoder and its toggle synchroniser
`timescale 1ns/1ps
interface toggle_sync_if;
    logic srcToggle;
    logic stageTwo;
    logic stageThree;

    modport owner (output srcToggle, input stageTwo, input stageThree);
    modport sync  (input srcToggle, output stageTwo, output stageThree);
endinterface

// File: verilog/toggle_sync.sv
// Three-stage synchroniser for the byte toggle from the link domain
`timescale 1ns/1ps
module toggle_sync (
    // System clock and control
    input  wire logic     clk,
    input  wire logic     sys_rst,
    input  wire logic     clkEn,
    // Toggle crossing
    toggle_sync_if.sync   link
);
    logic [xip_write_pkg::SYNC_STAGES-1:0] stage_q;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage_q <= '0;
        end else if (clkEn) begin
            stage_q <= {stage_q[xip_write_pkg::SYNC_STAGES-2:0], link.srcToggle};
        end
    end

    assign link.stageTwo   = stage_q[1];
    assign link.stageThree = stage_q[2];

    stage_order_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn |=> (stage_q[2] == $past(stage_q[1])))
        else $error("third stage did not follow second");
endmodule

// File: verilog/xip_write_decoder.sv
// Continuous-mode multi-lane write decoder: link deserialiser and array write port
`timescale 1ns/1ps
module xip_write_decoder (
    // System clock domain
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    // Status register view
    input  wire logic [7:0]  firstStatusReg,
    // Serial link
    input  wire logic        linkClk,
    input  wire logic        chipSelN,
    input  wire logic [3:0]  laneIn,
    output logic [3:0]       laneOut,
    output logic [3:0]       laneOeN,
    // Memory array write port
    output logic             memWe,
    output logic [20:0]      memAddr,
    output logic [7:0]       memData
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pins: writes only receive, lanes never driven
    assign laneOut = '0;
    assign laneOeN = '1;

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain reset source, held in the system domain
    logic linkRst_q;

    always_ff @(posedge clk) begin
        linkRst_q <= sys_rst;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain state
    xip_write_pkg::link_state_t state_q;
    xip_write_pkg::cmd_t        cmd_q;
    xip_write_pkg::cmd_t        contCmd_q;
    logic                       contValid_q;
    logic [3:0]                 bitCnt_q;
    logic [7:0]                 shift_q;
    logic [1:0]                 addrByte_q;
    logic [20:0]                addr_q;
    logic [3:0]                 hiNib_q;
    logic                       half_q;
    logic [3:0]                 negNib_q;
    logic [7:0]                 outByte_q;
    logic [20:0]                outAddr_q;
    logic                       tog_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Effective state: first edge of a frame resolves opcode or skipped opcode
    xip_write_pkg::link_state_t effState;
    xip_write_pkg::cmd_t        effCmd;
    logic                       startFrame;

    assign startFrame = (state_q == xip_write_pkg::ST_START);
    assign effState   = !startFrame ? state_q :
                        contValid_q ? xip_write_pkg::ST_ADDR :
                                      xip_write_pkg::ST_OPCODE;
    assign effCmd     = startFrame ? (contValid_q ? contCmd_q : xip_write_pkg::CMD_NONE)
                                   : cmd_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Lane width per phase
    logic inHeader;
    logic inData;
    logic ddrPhase;
    logic [3:0] width;

    assign inHeader = (effState == xip_write_pkg::ST_ADDR) ||
                      (effState == xip_write_pkg::ST_MODE);
    assign inData   = (effState == xip_write_pkg::ST_DATA);
    assign ddrPhase = (effCmd == xip_write_pkg::CMD_DDR_FAST) && (inHeader || inData);

    assign width = (inHeader && effCmd == xip_write_pkg::CMD_TWO_ADDR)  ? xip_write_pkg::WIDTH_TWO
                 : (inData && effCmd == xip_write_pkg::CMD_TWO_ADDR)    ? xip_write_pkg::WIDTH_TWO
                 : (inData && effCmd == xip_write_pkg::CMD_TWO_DATA)    ? xip_write_pkg::WIDTH_TWO
                 : (inData && effCmd == xip_write_pkg::CMD_FOUR_DATA)   ? xip_write_pkg::WIDTH_FOUR
                 : xip_write_pkg::WIDTH_ONE;

    ////////////////////////////////////////////////////////////////////////////////
    // Shifting and byte completion
    logic [7:0] sdrShift;
    logic [3:0] bitNext;
    logic       byteDone;
    logic [7:0] byteVal;

    assign sdrShift = (width == xip_write_pkg::WIDTH_FOUR) ? {shift_q[3:0], laneIn[3:0]}
                    : (width == xip_write_pkg::WIDTH_TWO)  ? {shift_q[5:0], laneIn[1:0]}
                    : {shift_q[6:0], laneIn[0]};
    assign bitNext  = bitCnt_q + width;
    assign byteDone = ddrPhase ? half_q : (bitNext == xip_write_pkg::BYTE_BITS);
    assign byteVal  = ddrPhase ? {hiNib_q, negNib_q} : sdrShift;

    ////////////////////////////////////////////////////////////////////////////////
    // Opcode decode and mode byte decision
    xip_write_pkg::cmd_t opCmd;
    logic                modeCont;
    logic                modeByte;

    assign opCmd = (sdrShift == xip_write_pkg::OP_FAST)      ? xip_write_pkg::CMD_FAST
                 : (sdrShift == xip_write_pkg::OP_DDR_FAST)  ? xip_write_pkg::CMD_DDR_FAST
                 : (sdrShift == xip_write_pkg::OP_TWO_DATA)  ? xip_write_pkg::CMD_TWO_DATA
                 : (sdrShift == xip_write_pkg::OP_TWO_ADDR)  ? xip_write_pkg::CMD_TWO_ADDR
                 : (sdrShift == xip_write_pkg::OP_FOUR_DATA) ? xip_write_pkg::CMD_FOUR_DATA
                 : xip_write_pkg::CMD_NONE;

    assign modeByte = byteDone && (effState == xip_write_pkg::ST_MODE);
    assign modeCont = (effCmd == xip_write_pkg::CMD_DDR_FAST)
                    ? (byteVal == xip_write_pkg::MODE_DDR_CONT)
                    : (byteVal[7:4] == xip_write_pkg::MODE_CONT_NIB);

    ////////////////////////////////////////////////////////////////////////////////
    // Next state after a byte
    xip_write_pkg::link_state_t afterByte;

    always_comb begin
        afterByte = effState;
        unique case (effState)
            xip_write_pkg::ST_START:  afterByte = xip_write_pkg::ST_OPCODE;
            xip_write_pkg::ST_OPCODE: afterByte = (opCmd == xip_write_pkg::CMD_NONE)
                                                ? xip_write_pkg::ST_IGNORE : xip_write_pkg::ST_ADDR;
            xip_write_pkg::ST_ADDR:   afterByte = (addrByte_q == xip_write_pkg::ADDR_LAST_BYTE)
                                                ? xip_write_pkg::ST_MODE : xip_write_pkg::ST_ADDR;
            xip_write_pkg::ST_MODE:   afterByte = xip_write_pkg::ST_DATA;
            xip_write_pkg::ST_DATA:   afterByte = xip_write_pkg::ST_DATA;
            xip_write_pkg::ST_IGNORE: afterByte = xip_write_pkg::ST_IGNORE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Falling-edge nibble for dual-edge phases, cleared by frame end
    always_ff @(negedge linkClk or posedge chipSelN) begin
        if (chipSelN) begin
            negNib_q <= '0;
        end else begin
            negNib_q <= laneIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame sequencer, cleared when select rises
    always_ff @(posedge linkClk or posedge chipSelN) begin
        if (chipSelN) begin
            state_q    <= xip_write_pkg::ST_START;
            cmd_q      <= xip_write_pkg::CMD_NONE;
            bitCnt_q   <= '0;
            shift_q    <= '0;
            addrByte_q <= '0;
            hiNib_q    <= '0;
            half_q     <= 1'b0;
        end else begin
            state_q    <= byteDone ? afterByte : effState;
            cmd_q      <= (effState == xip_write_pkg::ST_OPCODE && byteDone) ? opCmd : effCmd;
            bitCnt_q   <= (byteDone || ddrPhase) ? '0 : bitNext;
            shift_q    <= sdrShift;
            hiNib_q    <= laneIn;
            half_q     <= ddrPhase;
            if (byteDone && effState == xip_write_pkg::ST_ADDR) begin
                addrByte_q <= addrByte_q + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address and data hold; held words stay stable for the crossing
    always_ff @(posedge linkClk or posedge linkRst_q) begin
        if (linkRst_q) begin
            addr_q    <= xip_write_pkg::ADDR_ZERO;
            outByte_q <= '0;
            outAddr_q <= xip_write_pkg::ADDR_ZERO;
            tog_q     <= 1'b0;
        end else if (!chipSelN && byteDone) begin
            if (effState == xip_write_pkg::ST_ADDR) begin
                addr_q <= xip_write_pkg::ADDR_W'({addr_q, byteVal});
            end else if (effState == xip_write_pkg::ST_DATA) begin
                outByte_q <= byteVal;
                outAddr_q <= addr_q;
                addr_q    <= addr_q + 21'h1;
                tog_q     <= ~tog_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Continuous mode memory survives frames
    always_ff @(posedge linkClk or posedge linkRst_q) begin
        if (linkRst_q) begin
            contValid_q <= 1'b0;
            contCmd_q   <= xip_write_pkg::CMD_NONE;
        end else if (!chipSelN && modeByte) begin
            contValid_q <= modeCont;
            contCmd_q   <= effCmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Crossing into the system domain
    toggle_sync_if syncLink ();
    logic byteArrived;
    logic settled;
    logic seenTog_q;

    // A toggle counts once the second and third stages agree on it
    assign syncLink.srcToggle = tog_q;
    assign settled     = (syncLink.stageTwo == syncLink.stageThree);
    assign byteArrived = settled && (syncLink.stageThree != seenTog_q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seenTog_q <= 1'b0;
        end else if (clkEn && byteArrived) begin
            seenTog_q <= syncLink.stageThree;
        end
    end

    toggle_sync u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .link    (syncLink)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Array write port, gated by the write enable latch
    logic writeEnableLatch;
    logic doWrite;
    logic memWe_q;
    logic [20:0] memAddr_q;
    logic [7:0]  memData_q;

    // Latch is only read here, never cleared by a write
    assign writeEnableLatch = firstStatusReg[xip_write_pkg::WEL_BIT];
    assign doWrite = clkEn && byteArrived && writeEnableLatch;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            memWe_q   <= 1'b0;
            memAddr_q <= xip_write_pkg::ADDR_ZERO;
            memData_q <= '0;
        end else if (clkEn) begin
            memWe_q <= doWrite;
            if (doWrite) begin
                memAddr_q <= outAddr_q;
                memData_q <= outByte_q;
            end
        end
    end

    assign memWe   = memWe_q;
    assign memAddr = memAddr_q;
    assign memData = memData_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    wel_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        memWe_q |-> $past(writeEnableLatch) && $past(byteArrived))
        else $error("write issued without latch or byte");

    discard_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        (clkEn && byteArrived && !writeEnableLatch) |=> !memWe_q)
        else $error("byte written with latch clear");

    addr_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !memWe_q |-> $stable(memAddr_q) && $stable(memData_q))
        else $error("write port changed without a write");

    addr_wrap_a: assert property (@(posedge linkClk) disable iff (chipSelN || linkRst_q)
        (byteDone && effState == xip_write_pkg::ST_DATA && addr_q == xip_write_pkg::ADDR_MAX)
        |=> addr_q == xip_write_pkg::ADDR_ZERO)
        else $error("address did not wrap to zero");

    cont_enter_a: assert property (@(posedge linkClk) disable iff (chipSelN || linkRst_q)
        (modeByte && effCmd != xip_write_pkg::CMD_DDR_FAST
         && byteVal[7:4] == xip_write_pkg::MODE_CONT_NIB) |=> contValid_q)
        else $error("continuous mode not entered");

    ddr_exit_a: assert property (@(posedge linkClk) disable iff (chipSelN || linkRst_q)
        (modeByte && effCmd == xip_write_pkg::CMD_DDR_FAST
         && byteVal != xip_write_pkg::MODE_DDR_CONT) |=> !contValid_q)
        else $error("dual-edge continuous mode not left");

    skip_opcode_a: assert property (@(posedge linkClk) disable iff (chipSelN || linkRst_q)
        (startFrame && contValid_q) |=> (state_q == xip_write_pkg::ST_ADDR)
                                        && (cmd_q == $past(contCmd_q)))
        else $error("opcode expected in continuous mode");

    four_lane_a: assert property (@(posedge linkClk) disable iff (chipSelN || linkRst_q)
        (inData && effCmd == xip_write_pkg::CMD_FOUR_DATA && bitCnt_q == xip_write_pkg::WIDTH_FOUR)
        |=> tog_q != $past(tog_q) && outByte_q[3:0] == $past(laneIn))
        else $error("four-lane byte not completed in two clocks");

    ddr_enter_a: assert property (
        @(posedge linkClk) disable iff (chipSelN || linkRst_q)
        (modeByte && effCmd == xip_write_pkg::CMD_DDR_FAST
         && byteVal == xip_write_pkg::MODE_DDR_CONT)
        |=> contValid_q && contCmd_q == xip_write_pkg::CMD_DDR_FAST)
        else $error("dual-edge continuous mode not entered");

    cont_exit_a: assert property (
        @(posedge linkClk) disable iff (chipSelN || linkRst_q)
        (modeByte && effCmd != xip_write_pkg::CMD_DDR_FAST
         && byteVal[7:4] != xip_write_pkg::MODE_CONT_NIB) |=> !contValid_q)
        else $error("continuous mode not left");

    pair_data_a: assert property (
        @(posedge linkClk) disable iff (chipSelN || linkRst_q)
        (inData && effCmd == xip_write_pkg::CMD_TWO_DATA
         && bitCnt_q == xip_write_pkg::BYTE_BITS - xip_write_pkg::WIDTH_TWO)
        |=> tog_q != $past(tog_q) && outByte_q[1:0] == $past(laneIn[1:0]))
        else $error("two-lane data byte not completed");

    pair_io_data_a: assert property (
        @(posedge linkClk) disable iff (chipSelN || linkRst_q)
        (inData && effCmd == xip_write_pkg::CMD_TWO_ADDR
         && bitCnt_q == xip_write_pkg::BYTE_BITS - xip_write_pkg::WIDTH_TWO)
        |=> tog_q != $past(tog_q) && outByte_q[1:0] == $past(laneIn[1:0]))
        else $error("two-lane address/data byte not completed");

    pair_io_addr_a: assert property (
        @(posedge linkClk) disable iff (chipSelN || linkRst_q)
        (byteDone && effState == xip_write_pkg::ST_ADDR
         && effCmd == xip_write_pkg::CMD_TWO_ADDR)
        |=> addr_q[1:0] == $past(laneIn[1:0]))
        else $error("two-lane address bits misplaced");

    ignore_frame_a: assert property (
        @(posedge linkClk) disable iff (chipSelN || linkRst_q)
        (state_q == xip_write_pkg::ST_IGNORE) |=> $stable(tog_q) && !contValid_q)
        else $error("byte taken from an unknown command");

endmodule

// File: dv/spi_host_model.sv
// Serial host model driving the write decoder's link pins
`timescale 1ns/1ps
module spi_host_model (
    // Link pins
    output logic       linkClk,
    output logic       chipSelN,
    output logic [3:0] laneIn
);
    initial begin
        linkClk  = 1'b0;
        chipSelN = 1'b1;
        laneIn   = 4'h5;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shifter, MSB first; unused lanes toggle every cycle
    task automatic shift(input logic [31:0] v, input int nBits, input int w, input bit ddr);
        logic [3:0] nextLanes;
        for (int i = nBits; i > 0; i -= (ddr ? 8 : w)) begin
            if (ddr) begin
                laneIn = v[i-1 -: 4];
                #16 linkClk = 1'b1;
                #16 laneIn = v[i-5 -: 4];
                #16 linkClk = 1'b0;
                #16;
            end else begin
                nextLanes = ~laneIn;
                if (w == 1) nextLanes[0] = v[i-1];
                else if (w == 2) nextLanes[1:0] = v[i-1 -: 2];
                else nextLanes = v[i-1 -: 4];
                laneIn = nextLanes;
                #32 linkClk = 1'b1;
                #32 linkClk = 1'b0;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // One framed write; clock stands low outside frames
    task automatic run_frame(input logic [7:0] op, input bit sendOp, input logic [23:0] addr,
                             input logic [7:0] mode, input logic [31:0] d, input int n);
        bit ddr;
        int aw;
        int dw;
        ddr = (op === xip_write_pkg::OP_DDR_FAST);
        aw  = (op === xip_write_pkg::OP_TWO_ADDR) ? 2 : 1;
        dw  = (op === xip_write_pkg::OP_FOUR_DATA) ? 4 : (op[7:4] === 4'hA) ? 2 : 1;
        chipSelN = 1'b0;
        if (sendOp) shift({24'h0, op}, 8, 1, 1'b0);
        shift({addr, mode}, 32, aw, ddr);
        shift(d, 8 * n, dw, ddr);
        // Extra edge retires the last dual-edge byte
        if (ddr) shift(32'h0, 8, 1, 1'b1);
        #32 chipSelN = 1'b1;
        laneIn = ~laneIn;
        #96;
    endtask
endmodule

// File: dv/tb.sv
// Self-checking bench for the multi-lane continuous write decoder
`timescale 1ns/1ps
module tb;
    logic        clk;
    logic        sys_rst;
    logic        clkEn;
    logic [7:0]  firstStatusReg;
    logic        linkClk;
    logic        chipSelN;
    logic [3:0]  laneIn;
    logic [3:0]  laneOut;
    logic [3:0]  laneOeN;
    logic        memWe;
    logic [20:0] memAddr;
    logic [7:0]  memData;
    int          errCount;
    int          checks;
    int          cycles;
    logic [28:0] seenQ[$];

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    xip_write_decoder dut (
        .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .firstStatusReg(firstStatusReg),
        .linkClk(linkClk), .chipSelN(chipSelN), .laneIn(laneIn), .laneOut(laneOut),
        .laneOeN(laneOeN), .memWe(memWe), .memAddr(memAddr), .memData(memData)
    );

    spi_host_model host (.linkClk(linkClk), .chipSelN(chipSelN), .laneIn(laneIn));

    ////////////////////////////////////////////////////////////////////////////////
    // Write capture and hang guard
    always @(negedge clk) begin
        if (memWe === 1'b1) seenQ.push_back({memAddr, memData});
        cycles++;
        if (cycles == 40000) begin
            errCount++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic expect_bytes(input logic [20:0] a, input logic [31:0] d, input int n);
        logic [28:0] e;
        repeat (12) @(negedge clk);
        check(seenQ.size(), n, "write count");
        for (int k = 0; k < n && seenQ.size() > 0; k++) begin
            e = seenQ.pop_front();
            check({3'h0, e}, {3'h0, a + 21'(k), d[8*(n-1-k) +: 8]}, "write");
        end
        seenQ.delete();
    endtask

    task automatic frame(input logic [7:0] op, input bit sendOp, input logic [23:0] addr,
                         input logic [7:0] mode, input logic [31:0] d, input int n,
                         input bit wr);
        host.run_frame(op, sendOp, addr, mode, d, n);
        expect_bytes(addr[20:0], d, wr ? n : 0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_two_data();
        frame(xip_write_pkg::OP_TWO_DATA, 1, 24'h000100, 8'hA3, 32'hC35A, 2, 1);
        frame(xip_write_pkg::OP_TWO_DATA, 0, 24'h000200, 8'h00, 32'h96, 1, 1);
        frame(xip_write_pkg::OP_TWO_DATA, 0, 24'h000300, 8'h00, 32'h96, 1, 0);
        $display("two-lane data write done");
    endtask

    task automatic t_four_data();
        frame(xip_write_pkg::OP_FOUR_DATA, 1, 24'hE12345, 8'hAF, 32'h12EF, 2, 1);
        frame(xip_write_pkg::OP_FOUR_DATA, 0, 24'h000010, 8'h5A, 32'h7C, 1, 1);
        frame(xip_write_pkg::OP_FOUR_DATA, 0, 24'h000020, 8'h00, 32'h7C, 1, 0);
        check({24'h0, laneOut, laneOeN}, 32'h0000000F, "lanes stay inputs");
        $display("four-lane data write done");
    endtask

    task automatic t_two_addr();
        frame(xip_write_pkg::OP_TWO_ADDR, 1, 24'h1FFFFF, 8'hA0, 32'hA55A, 2, 1);
        frame(xip_write_pkg::OP_TWO_ADDR, 0, 24'h0ACE51, 8'h00, 32'h3C, 1, 1);
        frame(xip_write_pkg::OP_TWO_ADDR, 0, 24'h000040, 8'h00, 32'h3C, 1, 0);
        $display("two-lane address/data write done");
    endtask

    task automatic t_fast();
        frame(xip_write_pkg::OP_FAST, 1, 24'h000500, 8'hA7, 32'h01FE, 2, 1);
        frame(xip_write_pkg::OP_FAST, 0, 24'h000600, 8'hFF, 32'h81, 1, 1);
        frame(xip_write_pkg::OP_FAST, 0, 24'h000700, 8'h00, 32'h81, 1, 0);
        frame(xip_write_pkg::OP_FAST, 1, 24'h000800, 8'h00, 32'h42, 1, 1);
        $display("fast write done");
    endtask

    task automatic t_ddr();
        frame(xip_write_pkg::OP_DDR_FAST, 1, 24'h000900, 8'hA4, 32'h6B, 1, 1);
        frame(xip_write_pkg::OP_DDR_FAST, 0, 24'h000A00, 8'hA5, 32'h6B, 1, 0);
        frame(xip_write_pkg::OP_DDR_FAST, 1, 24'h000B00, 8'hA5, 32'hD2E1, 2, 1);
        frame(xip_write_pkg::OP_DDR_FAST, 0, 24'h000C00, 8'h00, 32'h1E, 1, 1);
        frame(xip_write_pkg::OP_DDR_FAST, 0, 24'h000D00, 8'h00, 32'h1E, 1, 0);
        $display("dual-edge fast write done");
    endtask

    task automatic t_wel();
        @(negedge clk);
        firstStatusReg = 8'hFD;
        frame(xip_write_pkg::OP_FAST, 1, 24'h000E00, 8'h00, 32'h55, 1, 0);
        @(negedge clk);
        firstStatusReg = 8'h02;
        frame(xip_write_pkg::OP_FAST, 1, 24'h000F00, 8'h00, 32'h55, 1, 1);
        $display("write enable latch gating done");
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        clkEn = 1'b1;
        firstStatusReg = 8'h02;
        errCount = 0;
        checks = 0;
        cycles = 0;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        t_two_data();
        t_four_data();
        t_two_addr();
        t_fast();
        t_ddr();
        t_wel();
        close_out();
    end
endmodule
